// ### pkg/wdg_pkg.sv
/*
  constants, field layout and types for the watchdog timer.
  assumes an 8-bit cpu i/o bus with byte addresses and one system clock.
*/
// Overview of operation
// - enable bit sticks until a reset
// - bit 6 picks cpu reset or nmi
// - cpu can poll the nmi source flag
// - every time-out sets read-only bit 5
// - external or debug reset clears indicator
// - only non-watchdog reset clears the indicator
// - bits 4:3 pick system or rtc clock
// - bits 1:0 pick 2^27/25/22/18 cycles
// - writing a5h then 5ah restarts the counter
// - any gap allowed between the two writes unless a time-out falls in it
// - restart register is write-only, reads nothing
package wdg_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 8;
  localparam logic [7:0]  CTL_ADDR    = 8'h93;
  localparam logic [7:0]  RESTART_ADDR = 8'h94;
  localparam logic [7:0]  KEY_FIRST   = 8'ha5;
  localparam logic [7:0]  KEY_SECOND  = 8'h5a;
  localparam logic [1:0]  CLK_SYSTEM  = 2'h0;
  localparam logic [1:0]  CLK_RTC     = 2'h1;
  localparam int          EXP_SEL0    = 27;
  localparam int          EXP_SEL1    = 25;
  localparam int          EXP_SEL2    = 22;
  localparam int          EXP_SEL3    = 18;
  localparam int          CNT_W       = 27;
  localparam logic [7:0]  READ_IDLE   = 8'h00;

  // control register layout, msb first
  typedef struct packed {
    logic       enable;
    logic       nmi_mode;
    logic       timeout_flag;
    logic [1:0] clk_sel;
    logic       rsv;
    logic [1:0] period_sel;
  } wdg_ctl_t;

  localparam wdg_ctl_t CTL_RESET = '{enable: 1'b0, nmi_mode: 1'b0, timeout_flag: 1'b0,
                                     clk_sel: 2'h0, rsv: 1'b0, period_sel: 2'h0};

  typedef enum logic [0:0] {
    UNLOCK_IDLE  = 1'b0,
    UNLOCK_ARMED = 1'b1
  } wdg_unlock_t;
endpackage

// ### hdl/wdg_top.sv
/*
  watchdog timer: control and restart registers on the cpu i/o bus,
  time-out counter, reset or nmi action, time-out indicator.
  assumes all inputs synchronous to clk; rtc_tick is a one-cycle pulse
  per real-time clock period, already brought into this domain.
*/
`timescale 1ns/1ns
module wdg_top #(
  parameter int CNT_W = wdg_pkg::CNT_W,
  parameter int EXP0  = wdg_pkg::EXP_SEL0,
  parameter int EXP1  = wdg_pkg::EXP_SEL1,
  parameter int EXP2  = wdg_pkg::EXP_SEL2,
  parameter int EXP3  = wdg_pkg::EXP_SEL3
)
(
  // clock and resets
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        debug_reset,
  // counting source
  input  wire logic                        rtc_tick,
  // cpu i/o bus
  input  wire logic [wdg_pkg::ADDR_W-1:0]  io_addr,
  input  wire logic                        io_wr,
  input  wire logic                        io_rd,
  input  wire logic [wdg_pkg::DATA_W-1:0]  io_wdata,
  output logic      [wdg_pkg::DATA_W-1:0]  io_rdata,
  // time-out actions
  output logic                             cpu_reset_req,
  output logic                             nmi_req,
  output logic                             timeout_flag
);

  wdg_pkg::wdg_ctl_t    ctl_reg;
  wdg_pkg::wdg_unlock_t unlock_reg;
  logic [CNT_W-1:0]     cnt_reg;
  logic                 cnt_step;
  logic                 timeout;
  logic                 restart;
  logic                 ctl_wr;
  logic                 rr_wr;
  logic                 ctl_clear;
  wdg_pkg::wdg_ctl_t    wr_fields;

  function automatic logic [CNT_W-1:0] period_last(input logic [1:0] sel);
    int e;
    case (sel)
      2'h0:    e = EXP0;
      2'h1:    e = EXP1;
      2'h2:    e = EXP2;
      default: e = EXP3;
    endcase
    return CNT_W'((64'h1 << e) - 64'h1);
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // write data seen through the control layout, so no bit index stands bare
  assign wr_fields = io_wdata;
  assign ctl_wr = io_wr && addr_hit(io_addr, wdg_pkg::CTL_ADDR);
  assign rr_wr  = io_wr && addr_hit(io_addr, wdg_pkg::RESTART_ADDR);

  // reserved clock codes never step, so a bad setting cannot fire
  always_comb
  begin
    case (ctl_reg.clk_sel)
      wdg_pkg::CLK_SYSTEM: cnt_step = 1'b1;
      wdg_pkg::CLK_RTC:    cnt_step = rtc_tick;
      default:             cnt_step = 1'b0;
    endcase
  end

  assign timeout = ctl_reg.enable && cnt_step
                   && cnt_reg == period_last(ctl_reg.period_sel);
  assign restart = rr_wr && io_wdata == wdg_pkg::KEY_SECOND
                   && unlock_reg == wdg_pkg::UNLOCK_ARMED && !timeout;

  // a watchdog reset clears control but not the indicator
  assign ctl_clear = rst || debug_reset || cpu_reset_req;

  // control fields and indicator in one process: the struct has one driver
  always_ff @(posedge clk)
  begin
    if (ctl_clear)
    begin
      ctl_reg.enable     <= wdg_pkg::CTL_RESET.enable;
      ctl_reg.nmi_mode   <= wdg_pkg::CTL_RESET.nmi_mode;
      ctl_reg.clk_sel    <= wdg_pkg::CTL_RESET.clk_sel;
      ctl_reg.period_sel <= wdg_pkg::CTL_RESET.period_sel;
    end
    else if (ctl_wr)
    begin
      ctl_reg.enable     <= ctl_reg.enable | wr_fields.enable;
      ctl_reg.nmi_mode   <= wr_fields.nmi_mode;
      ctl_reg.clk_sel    <= wr_fields.clk_sel;
      ctl_reg.period_sel <= wr_fields.period_sel;
    end
    // indicator: set wins over a same-cycle clearing reset
    if (timeout)
      ctl_reg.timeout_flag <= 1'b1;
    else if (rst || debug_reset)
      ctl_reg.timeout_flag <= wdg_pkg::CTL_RESET.timeout_flag;
    ctl_reg.rsv <= wdg_pkg::CTL_RESET.rsv;
  end

  assign timeout_flag = ctl_reg.timeout_flag;

  // counter
  always_ff @(posedge clk)
  begin
    if (ctl_clear || !ctl_reg.enable || restart || timeout)
      cnt_reg <= '0;
    else if (cnt_step)
      cnt_reg <= cnt_reg + CNT_W'(1);
  end

  // unlock sequence
  always_ff @(posedge clk)
  begin
    if (ctl_clear || timeout)
      unlock_reg <= wdg_pkg::UNLOCK_IDLE;
    else if (rr_wr)
    begin
      case (unlock_reg)
        wdg_pkg::UNLOCK_IDLE:
          unlock_reg <= io_wdata == wdg_pkg::KEY_FIRST ? wdg_pkg::UNLOCK_ARMED
                                                        : wdg_pkg::UNLOCK_IDLE;
        wdg_pkg::UNLOCK_ARMED:
          // a repeated first key keeps the arm; anything else drops it
          unlock_reg <= io_wdata == wdg_pkg::KEY_FIRST ? wdg_pkg::UNLOCK_ARMED
                                                        : wdg_pkg::UNLOCK_IDLE;
        default:
          unlock_reg <= wdg_pkg::UNLOCK_IDLE;
      endcase
    end
  end

  // time-out actions, one-cycle pulses
  always_ff @(posedge clk)
  begin
    if (rst || debug_reset)
    begin
      cpu_reset_req <= 1'b0;
      nmi_req       <= 1'b0;
    end
    else
    begin
      cpu_reset_req <= timeout && !ctl_reg.nmi_mode;
      nmi_req       <= timeout && ctl_reg.nmi_mode;
    end
  end

  // read data; the restart register reads as idle
  always_ff @(posedge clk)
  begin
    if (rst)
      io_rdata <= wdg_pkg::READ_IDLE;
    else if (io_rd && addr_hit(io_addr, wdg_pkg::CTL_ADDR))
      io_rdata <= ctl_reg;
    else
      io_rdata <= wdg_pkg::READ_IDLE;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_enable_sticky: assert property (
    ctl_reg.enable && !debug_reset && !cpu_reset_req |=> ctl_reg.enable)
    else $error("watchdog disabled without reset");

  a_action_select: assert property (
    timeout && !debug_reset |=> (nmi_req == $past(ctl_reg.nmi_mode))
                                && (cpu_reset_req == !$past(ctl_reg.nmi_mode)))
    else $error("wrong time-out action");

  a_nmi_source: assert property (
    nmi_req |-> timeout_flag)
    else $error("nmi without source flag");

  a_flag_set: assert property (
    timeout |=> timeout_flag)
    else $error("time-out did not set indicator");

  a_flag_ext_clear: assert property (
    debug_reset && !timeout |=> !timeout_flag)
    else $error("debug reset left indicator set");

  a_flag_hold: assert property (
    timeout_flag && !debug_reset |=> timeout_flag)
    else $error("indicator cleared by non-reset");

  a_clk_reserved: assert property (
    ctl_reg.clk_sel[1] && !restart && !ctl_clear |-> !timeout ##1 $stable(cnt_reg))
    else $error("reserved clock code counted");

  a_period_len: assert property (
    timeout |-> cnt_reg == period_last(ctl_reg.period_sel))
    else $error("time-out at wrong count");

  a_restart_reload: assert property (
    rr_wr && io_wdata == wdg_pkg::KEY_FIRST && !timeout && !debug_reset
    ##1 rr_wr && io_wdata == wdg_pkg::KEY_SECOND && !timeout && !debug_reset
    |=> cnt_reg == '0)
    else $error("restart sequence did not reload");

  a_armed_wait: assert property (
    unlock_reg == wdg_pkg::UNLOCK_ARMED && !rr_wr && !timeout && !ctl_clear
    |=> unlock_reg == wdg_pkg::UNLOCK_ARMED)
    else $error("arm lost while waiting");

  a_rr_no_read: assert property (
    io_rd && addr_hit(io_addr, wdg_pkg::RESTART_ADDR) |=> io_rdata == wdg_pkg::READ_IDLE)
    else $error("restart register returned data");

  a_count_step: assert property (
    ctl_reg.enable && cnt_step && !timeout && !restart && !ctl_clear
    |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
    else $error("counter did not step");

  c_nmi_timeout:  cover property (nmi_req);
  c_reset_timeout: cover property (cpu_reset_req ##1 !ctl_reg.enable && timeout_flag);
  c_restart:      cover property (restart);
  c_rtc_count:    cover property (ctl_reg.clk_sel == wdg_pkg::CLK_RTC && timeout);

endmodule

// ### sim/tb.sv
/*
  self-checking bench for the watchdog timer top level.
  assumes the short periods given below through the exponent parameters.
*/
`timescale 1ns/1ns
module tb;
  // short periods keep the run small
  localparam int E0 = 4, E1 = 3, E2 = 2, E3 = 1;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       debug_reset = 1'b0;
  logic       rtc_tick = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic       io_wr = 1'b0;
  logic       io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic       cpu_reset_req;
  logic       nmi_req;
  logic       timeout_flag;
  logic [7:0] rd_val;
  int         bad_count = 0;
  int         checks = 0;
  int         exps [4] = '{E0, E1, E2, E3};
  // writes made while disabled, and what reads back
  logic [7:0] row_w [5] = '{8'h7f, 8'h24, 8'h13, 8'h0b, 8'h00};
  logic [7:0] row_e [5] = '{8'h5b, 8'h00, 8'h13, 8'h0b, 8'h00};

  wdg_top #(.CNT_W(4), .EXP0(E0), .EXP1(E1), .EXP2(E2), .EXP3(E3)) i_dut (
    .clk           (clk),
    .rst           (rst),
    .debug_reset   (debug_reset),
    .rtc_tick      (rtc_tick),
    .io_addr       (io_addr),
    .io_wr         (io_wr),
    .io_rd         (io_rd),
    .io_wdata      (io_wdata),
    .io_rdata      (io_rdata),
    .cpu_reset_req (cpu_reset_req),
    .nmi_req       (nmi_req),
    .timeout_flag  (timeout_flag)
  );

  always #5 clk = ~clk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobes stay up between back-to-back accesses; idle drops them
  task automatic idle(input int n);
    io_wr = 1'b0;
    io_rd = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_rd = 1'b0;
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    io_wr = 1'b0;
    io_addr = a;
    io_rd = 1'b1;
    @(posedge clk);
    #1;
    v = io_rdata;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    idle(8);
    rst = 1'b0;
  endtask

  // pulse must show exactly n edges after the current one
  task automatic expect_pulse(input int n, input logic nmi_sel);
    idle(n - 1);
    chk_bit(cpu_reset_req | nmi_req, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(cpu_reset_req, !nmi_sel);
    chk_bit(nmi_req, nmi_sel);
  endtask

  initial
  begin
    #200000;
    bad_count++;
    final_report();
  end

  initial
  begin
    do_reset();
    rd(8'h93, rd_val);
    chk_byte(rd_val, 8'h00);
    chk_bit(timeout_flag, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h93, row_w[i]);
      rd(8'h93, rd_val);
      chk_byte(rd_val, row_e[i]);
    end
    wr(8'h94, 8'ha5);
    rd(8'h94, rd_val);
    chk_byte(rd_val, 8'h00);
    rd(8'h95, rd_val);
    chk_byte(rd_val, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      do_reset();
      wr(8'h93, 8'hc0 | 8'(s));
      expect_pulse(1 << exps[s], 1'b1);
      chk_bit(timeout_flag, 1'b1);
      expect_pulse(1 << exps[s], 1'b1);
      rd(8'h93, rd_val);
      chk_byte(rd_val, 8'he0 | 8'(s));
    end
    $display("test nmi periods done");
    do_reset();
    wr(8'h93, 8'h80);
    wr(8'h93, 8'h00);
    expect_pulse((1 << E0) - 1, 1'b0);
    chk_bit(timeout_flag, 1'b1);
    wr(8'h93, 8'h00);
    rd(8'h93, rd_val);
    chk_byte(rd_val, 8'h20);
    debug_reset = 1'b1;
    idle(1);
    debug_reset = 1'b0;
    rd(8'h93, rd_val);
    chk_byte(rd_val, 8'h00);
    $display("test cpu reset done");
    do_reset();
    wr(8'h93, 8'h80);
    wr(8'h94, 8'ha5);
    idle(6);
    rd(8'h93, rd_val);
    chk_byte(rd_val, 8'h80);
    wr(8'h94, 8'h5a);
    wr(8'h94, 8'ha5);
    wr(8'h94, 8'h11);
    wr(8'h94, 8'h5a);
    expect_pulse((1 << E0) - 3, 1'b0);
    do_reset();
    wr(8'h93, 8'h80);
    idle(3);
    wr(8'h94, 8'ha5);
    wr(8'h94, 8'h5a);
    expect_pulse(1 << E0, 1'b0);
    $display("test restart done");
    do_reset();
    wr(8'h93, 8'h90);
    idle(40);
    chk_bit(timeout_flag, 1'b0);
    wr(8'h93, 8'h88);
    for (int t = 1; t <= 16; t++)
    begin
      idle(3);
      rtc_tick = 1'b1;
      @(posedge clk);
      #1 rtc_tick = 1'b0;
    end
    chk_bit(cpu_reset_req, 1'b1);
    $display("test clock select done");
    final_report();
  end
endmodule
